// [tcj_pkg.sv]
package tcj_pkg;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_TIME    = 8'h04;
   localparam logic [7:0]  OFS_DATE    = 8'h08;
   localparam logic [7:0]  OFS_ZONE    = 8'h0C;
   localparam logic [7:0]  OFS_SHIFT   = 8'h10;
   localparam logic [7:0]  OFS_JAM     = 8'h14;
   localparam logic [7:0]  OFS_ONCE    = 8'h18;
   localparam logic [7:0]  OFS_RSTART  = 8'h1C;
   localparam logic [7:0]  OFS_REND    = 8'h20;
   localparam logic [7:0]  OFS_LOCAL   = 8'h24;
   // control fields
   localparam int          FLD_RATE    = 0;
   localparam int          FLD_JAM_EN  = 3;
   localparam int          FLD_MODE    = 4;
   // time code fields
   localparam int          FLD_FF      = 0;
   localparam int          FLD_SS      = 8;
   localparam int          FLD_MM      = 16;
   localparam int          FLD_HH      = 24;
   localparam int          FLD_DST_ON  = 31;
   // date fields
   localparam int          FLD_MON     = 0;
   localparam int          FLD_DOM     = 8;
   localparam int          FLD_WDAY    = 16;
   localparam int          FLD_LEAP    = 24;
   // offset and event fields
   localparam int          FLD_EMIN    = 0;
   localparam int          FLD_EHR     = 8;
   localparam int          FLD_OSIGN   = 15;
   localparam int          FLD_EWDAY   = 16;
   localparam int          FLD_EDOM    = 16;
   localparam int          FLD_EORD    = 20;
   localparam int          FLD_EMON    = 24;
   localparam logic [31:0] MASK_OFS    = 32'h0000_9F3F;
   localparam logic [31:0] MASK_JAM    = 32'h0000_1F3F;
   localparam logic [31:0] MASK_ONCE   = 32'h0F1F_1F3F;
   localparam logic [31:0] MASK_RULE   = 32'h0F77_1F3F;
   localparam logic [2:0]  ORD_LAST    = 3'h5;
   // counting constants
   localparam logic [5:0]  SEC_TOP     = 6'h3B;
   localparam logic [10:0] MIN_PER_HR  = 11'h03C;
   localparam logic [10:0] MIN_TOP     = 11'h59F;
   localparam int          MIN_PER_DAY = 1440;
   localparam logic [2:0]  SKIP_30     = 3'h2;
   localparam logic [2:0]  SKIP_60     = 3'h4;
   // reset values
   localparam logic [3:0]  RST_MON     = 4'h1;
   localparam logic [4:0]  RST_DOM     = 5'h01;

   typedef enum logic [2:0] {
      RATE_24   = 3'h0,
      RATE_25   = 3'h1,
      RATE_30   = 3'h2,
      RATE_2997 = 3'h3,
      RATE_50   = 3'h4,
      RATE_60   = 3'h5,
      RATE_5994 = 3'h6
   } tcj_rate_e;

   typedef enum logic [1:0] {
      MODE_OFF   = 2'h0,
      MODE_ONCE  = 2'h1,
      MODE_RECUR = 2'h3
   } tcj_mode_e;

   localparam tcj_rate_e   RST_RATE    = RATE_2997;
endpackage : tcj_pkg

// [tcj_rule_match.sv]
`timescale 1ns/1ps
`default_nettype none
module tcj_rule_match (
   input  wire logic [3:0]  cur_mon,
   input  wire logic [4:0]  cur_dom,
   input  wire logic [2:0]  cur_wday,
   input  wire logic [4:0]  cur_dim,
   input  wire logic [10:0] cur_mod,
   input  wire logic [31:0] rule,
   output logic             hit
);
   logic [2:0]  nth;
   logic        last;
   logic [10:0] ev_mod;

   always_comb begin
      nth    = 3'((cur_dom - 5'h01) / 5'h07) + 3'h1;
      last   = ({1'b0, cur_dom} + 6'h07) > {1'b0, cur_dim};
      ev_mod = 11'(rule[tcj_pkg::FLD_EHR +: 5]) * tcj_pkg::MIN_PER_HR
             + 11'(rule[tcj_pkg::FLD_EMIN +: 6]);
      // month, weekday, ordinal or last, time of day
      hit = (rule[tcj_pkg::FLD_EMON +: 4] == cur_mon)              // R15
         && (rule[tcj_pkg::FLD_EWDAY +: 3] == cur_wday)
         && ((rule[tcj_pkg::FLD_EORD +: 3] == tcj_pkg::ORD_LAST) ? last
             : (rule[tcj_pkg::FLD_EORD +: 3] == nth))
         && (ev_mod == cur_mod);
   end
endmodule : tcj_rule_match
`default_nettype wire

// [tcj_timecode.sv]
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: 30 fps frames run 00..29 then wrap.
// R2: frame skips only at 29.97 or 59.94.
// R3: drop mode skips 00,01 (00..03 at 59.94) at minute change.
// R4: no skip when new minute is tenth.
// R5: daily jam skips 2 or 4 extra counts.
// R6: jam extra is 2 at 29.97, 4 at 59.94.
// R7: one enable bit turns daily jam on.
// R8: jam time minutes are tens past hour; the code accepts any 6-bit minute value.
// R9: local time adds zone and shift offsets.
// R10: disabled schedule applies no shift.
// R11: once mode applies offset, returns disabled.
// R12: once event given by date and time.
// R13: recurring mode repeats start/end every year.
// R14: shift offset signed hours and minutes.
// R15: events are month, weekday, ordinal, time.
// R16: shift added at start, removed at end.
module tcj_timecode #(
   parameter int FRAME_W = 6
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic [31:0]             hrdata,
   output logic                    hresp,
   input  wire logic               frame_tick,
   output logic [4:0]              tc_hh,
   output logic [5:0]              tc_mm,
   output logic [5:0]              tc_ss,
   output logic [FRAME_W-1:0]      tc_ff,
   output logic                    tc_drop,
   output logic                    shift_active
);
   if (FRAME_W < 6) begin : g_chk
      $error("FRAME_W too small for 60 frames");
   end

   function automatic logic [5:0] frame_top(input logic [2:0] r);
      unique case (r)
         tcj_pkg::RATE_24:                    frame_top = 6'h17;
         tcj_pkg::RATE_25:                    frame_top = 6'h18;
         tcj_pkg::RATE_50:                    frame_top = 6'h31;
         tcj_pkg::RATE_60, tcj_pkg::RATE_5994: frame_top = 6'h3B;
         default:                             frame_top = 6'h1D;
      endcase
   endfunction : frame_top

   function automatic logic signed [12:0] ofs_min(input logic [31:0] w);
      logic [12:0] mag;
      mag = 13'(w[tcj_pkg::FLD_EHR +: 5]) * 13'h03C + 13'(w[tcj_pkg::FLD_EMIN +: 6]);
      ofs_min = w[tcj_pkg::FLD_OSIGN] ? -signed'(mag) : signed'(mag);  // R14
   endfunction : ofs_min

   function automatic logic [10:0] loc_of(input logic [10:0] b, input logic signed [12:0] a);
      int s;
      s = int'(b) + int'(a) + 2 * tcj_pkg::MIN_PER_DAY;
      loc_of = 11'(s % tcj_pkg::MIN_PER_DAY);
   endfunction : loc_of

   function automatic logic [4:0] days_in(input logic [3:0] m, input logic lp);
      unique case (m)
         4'h2:                      days_in = lp ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB:    days_in = 5'h1E;
         default:                   days_in = 5'h1F;
      endcase
   endfunction : days_in

   // bus address phase
   logic               a_valid_reg, a_valid_next;
   logic               a_we_reg,    a_we_next;
   logic [7:0]         a_addr_reg,  a_addr_next;
   logic               wr_en;
   // configuration
   logic [2:0]         rate_reg,    rate_next;
   logic               jam_en_reg,  jam_en_next;
   logic [31:0]        zone_reg,    zone_next;
   logic [31:0]        shift_reg,   shift_next;
   logic [31:0]        jam_reg,     jam_next;
   logic [31:0]        once_reg,    once_next;
   logic [31:0]        rst_reg,     rst_next;
   logic [31:0]        rend_reg,    rend_next;
   // counter and calendar
   logic [FRAME_W-1:0] ff_reg,      ff_next;
   logic [5:0]         ss_reg,      ss_next;
   logic [5:0]         mm_reg,      mm_next;
   logic [4:0]         hh_reg,      hh_next;
   logic [3:0]         mon_reg,     mon_next;
   logic [4:0]         dom_reg,     dom_next;
   logic [2:0]         wday_reg,    wday_next;
   logic               leap_reg,    leap_next;
   // schedule
   logic [1:0]         mode_reg,    mode_next;
   logic               dst_on_reg,  dst_on_next;
   logic signed [12:0] fold_reg,    fold_next;
   logic [10:0]        locm_reg,    locm_next;
   // outputs
   logic [FRAME_W-1:0] tff_reg,     tff_next;
   logic [5:0]         tss_reg,     tss_next;
   logic [5:0]         tmm_reg,     tmm_next;
   logic [4:0]         thh_reg,     thh_next;
   // combinational
   logic [5:0]         top;
   logic [2:0]         drop;
   logic [10:0]        cnt_mod, next_mod, loc_mod, jam_mod, once_mod;
   logic signed [12:0] tot_ofs;
   logic               jam_hit, ev, day_wrap, once_hit, start_hit, end_hit;
   logic [4:0]         dim;

   always_comb begin
      top      = frame_top(rate_reg);
      drop     = (rate_reg == tcj_pkg::RATE_2997) ? tcj_pkg::SKIP_30      // R2 R6
               : (rate_reg == tcj_pkg::RATE_5994) ? tcj_pkg::SKIP_60 : 3'h0;
      cnt_mod  = 11'(hh_reg) * tcj_pkg::MIN_PER_HR + 11'(mm_reg);
      next_mod = (cnt_mod == tcj_pkg::MIN_TOP) ? 11'h000 : cnt_mod + 11'h001;
      tot_ofs  = ofs_min(zone_reg) + fold_reg                            // R9
               + ((mode_reg == tcj_pkg::MODE_RECUR && dst_on_reg)       // R10
                  ? ofs_min(shift_reg) : 13'sh0000);
      loc_mod  = loc_of(cnt_mod, tot_ofs);                               // R9
      jam_mod  = 11'(jam_reg[tcj_pkg::FLD_EHR +: 5]) * tcj_pkg::MIN_PER_HR
               + 11'(jam_reg[tcj_pkg::FLD_EMIN +: 6]);
      once_mod = 11'(once_reg[tcj_pkg::FLD_EHR +: 5]) * tcj_pkg::MIN_PER_HR
               + 11'(once_reg[tcj_pkg::FLD_EMIN +: 6]);
      dim      = days_in(mon_reg, leap_reg);
      ev       = loc_mod != locm_reg;
      day_wrap = (locm_reg == tcj_pkg::MIN_TOP) && (loc_mod == 11'h000);
      wr_en    = a_valid_reg && a_we_reg;
   end

   tcj_rule_match u_start (
      .cur_mon  (mon_reg),
      .cur_dom  (dom_reg),
      .cur_wday (wday_reg),
      .cur_dim  (dim),
      .cur_mod  (loc_mod),
      .rule     (rst_reg),
      .hit      (start_hit)
   );

   tcj_rule_match u_end (
      .cur_mon  (mon_reg),
      .cur_dom  (dom_reg),
      .cur_wday (wday_reg),
      .cur_dim  (dim),
      .cur_mod  (loc_mod),
      .rule     (rend_reg),
      .hit      (end_hit)
   );

   // bus slave: zero wait states, always OKAY
   always_comb begin
      a_valid_next = hsel && hready && htrans[1];
      a_we_next    = hwrite;
      a_addr_next  = haddr[7:0];
      hreadyout    = 1'b1;
      hresp        = 1'b0;
      unique case (a_addr_reg)
         tcj_pkg::OFS_CTRL:   hrdata = {26'h0, mode_reg, jam_en_reg, rate_reg};
         tcj_pkg::OFS_TIME:   hrdata = {3'h0, hh_reg, 2'h0, mm_reg, 2'h0, ss_reg,
                                        8'(ff_reg)};
         tcj_pkg::OFS_DATE:   hrdata = {7'h0, leap_reg, 5'h0, wday_reg, 3'h0, dom_reg,
                                        4'h0, mon_reg};
         tcj_pkg::OFS_ZONE:   hrdata = zone_reg;
         tcj_pkg::OFS_SHIFT:  hrdata = shift_reg;
         tcj_pkg::OFS_JAM:    hrdata = jam_reg;
         tcj_pkg::OFS_ONCE:   hrdata = once_reg;
         tcj_pkg::OFS_RSTART: hrdata = rst_reg;
         tcj_pkg::OFS_REND:   hrdata = rend_reg;
         tcj_pkg::OFS_LOCAL:  hrdata = {dst_on_reg, 2'h0, thh_reg, 2'h0, tmm_reg, 2'h0,
                                        tss_reg, 8'(tff_reg)};
         default:             hrdata = 32'h0000_0000;
      endcase
   end

   // configuration registers
   always_comb begin
      rate_next   = rate_reg;
      jam_en_next = jam_en_reg;
      zone_next   = zone_reg;
      shift_next  = shift_reg;
      jam_next    = jam_reg;
      once_next   = once_reg;
      rst_next    = rst_reg;
      rend_next   = rend_reg;
      if (wr_en) begin
         unique case (a_addr_reg)
            tcj_pkg::OFS_CTRL: begin
               rate_next   = hwdata[tcj_pkg::FLD_RATE +: 3];
               jam_en_next = hwdata[tcj_pkg::FLD_JAM_EN];                // R7
            end
            tcj_pkg::OFS_ZONE:   zone_next  = hwdata & tcj_pkg::MASK_OFS;
            tcj_pkg::OFS_SHIFT:  shift_next = hwdata & tcj_pkg::MASK_OFS;
            tcj_pkg::OFS_JAM:    jam_next   = hwdata & tcj_pkg::MASK_JAM;
            tcj_pkg::OFS_ONCE:   once_next  = hwdata & tcj_pkg::MASK_ONCE;
            tcj_pkg::OFS_RSTART: rst_next   = hwdata & tcj_pkg::MASK_RULE;
            tcj_pkg::OFS_REND:   rend_next  = hwdata & tcj_pkg::MASK_RULE;
            default:             ;
         endcase
      end
   end

   // time code counter and calendar
   always_comb begin
      ff_next   = ff_reg;
      ss_next   = ss_reg;
      mm_next   = mm_reg;
      hh_next   = hh_reg;
      mon_next  = mon_reg;
      dom_next  = dom_reg;
      wday_next = wday_reg;
      leap_next = leap_reg;
      jam_hit   = 1'b0;
      if (frame_tick) begin
         if (6'(ff_reg) != top) begin
            ff_next = ff_reg + 1'b1;                                     // R1
         end else if (ss_reg != tcj_pkg::SEC_TOP) begin
            ff_next = '0;                                                // R1
            ss_next = ss_reg + 6'h01;
         end else begin
            ss_next = 6'h00;
            mm_next = 6'(next_mod % tcj_pkg::MIN_PER_HR);
            hh_next = 5'(next_mod / tcj_pkg::MIN_PER_HR);
            jam_hit = jam_en_reg && (loc_of(next_mod, tot_ofs) == jam_mod);   // R5 R7
            ff_next = FRAME_W'(((next_mod % 11'h00A) != 11'h000) ? drop : 3'h0) // R3 R4
                    + FRAME_W'(jam_hit ? drop : 3'h0);                  // R6
         end
      end
      if (day_wrap) begin
         wday_next = (wday_reg == 3'h6) ? 3'h0 : wday_reg + 3'h1;
         if (dom_reg == dim) begin
            dom_next = tcj_pkg::RST_DOM;
            mon_next = (mon_reg == 4'hC) ? tcj_pkg::RST_MON : mon_reg + 4'h1;
         end else begin
            dom_next = dom_reg + 5'h01;
         end
      end
      if (wr_en && a_addr_reg == tcj_pkg::OFS_TIME) begin
         ff_next = FRAME_W'(hwdata[tcj_pkg::FLD_FF +: 6]);
         ss_next = hwdata[tcj_pkg::FLD_SS +: 6];
         mm_next = hwdata[tcj_pkg::FLD_MM +: 6];
         hh_next = hwdata[tcj_pkg::FLD_HH +: 5];
      end
      if (wr_en && a_addr_reg == tcj_pkg::OFS_DATE) begin
         mon_next  = hwdata[tcj_pkg::FLD_MON +: 4];
         dom_next  = hwdata[tcj_pkg::FLD_DOM +: 5];
         wday_next = hwdata[tcj_pkg::FLD_WDAY +: 3];
         leap_next = hwdata[tcj_pkg::FLD_LEAP];
      end
   end

   // seasonal shift schedule
   always_comb begin
      once_hit    = ev && (mode_reg == tcj_pkg::MODE_ONCE)
                 && (once_reg[tcj_pkg::FLD_EMON +: 4] == mon_reg)
                 && (once_reg[tcj_pkg::FLD_EDOM +: 5] == dom_reg)
                 && (once_mod == loc_mod);
      mode_next   = mode_reg;
      dst_on_next = dst_on_reg;
      fold_next   = fold_reg;
      locm_next   = loc_mod;
      if (once_hit) begin
         fold_next = fold_reg + ofs_min(shift_reg);                      // R11
         mode_next = tcj_pkg::MODE_OFF;                                  // R11
      end
      if (mode_reg != tcj_pkg::MODE_RECUR) begin
         dst_on_next = 1'b0;                                             // R10
      end else if (ev && start_hit) begin
         dst_on_next = 1'b1;                                             // R13 R16
      end else if (ev && end_hit) begin
         dst_on_next = 1'b0;                                             // R16
      end
      if (wr_en && a_addr_reg == tcj_pkg::OFS_CTRL) begin
         mode_next = hwdata[tcj_pkg::FLD_MODE +: 2];
      end
      tff_next = ff_reg;
      tss_next = ss_reg;
      tmm_next = 6'(loc_mod % tcj_pkg::MIN_PER_HR);                      // R9
      thh_next = 5'(loc_mod / tcj_pkg::MIN_PER_HR);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_valid_reg <= 1'b0;
         a_we_reg    <= 1'b0;
         a_addr_reg  <= 8'h00;
         rate_reg    <= tcj_pkg::RST_RATE;
         jam_en_reg  <= 1'b0;
         zone_reg    <= 32'h0000_0000;
         shift_reg   <= 32'h0000_0000;
         jam_reg     <= 32'h0000_0000;
         once_reg    <= 32'h0000_0000;
         rst_reg     <= 32'h0000_0000;
         rend_reg    <= 32'h0000_0000;
         ff_reg      <= '0;
         ss_reg      <= 6'h00;
         mm_reg      <= 6'h00;
         hh_reg      <= 5'h00;
         mon_reg     <= tcj_pkg::RST_MON;
         dom_reg     <= tcj_pkg::RST_DOM;
         wday_reg    <= 3'h0;
         leap_reg    <= 1'b0;
         mode_reg    <= tcj_pkg::MODE_OFF;
         dst_on_reg  <= 1'b0;
         fold_reg    <= 13'sh0000;
         locm_reg    <= 11'h000;
         tff_reg     <= '0;
         tss_reg     <= 6'h00;
         tmm_reg     <= 6'h00;
         thh_reg     <= 5'h00;
      end else begin
         a_valid_reg <= a_valid_next;
         a_we_reg    <= a_we_next;
         a_addr_reg  <= a_addr_next;
         rate_reg    <= rate_next;
         jam_en_reg  <= jam_en_next;
         zone_reg    <= zone_next;
         shift_reg   <= shift_next;
         jam_reg     <= jam_next;
         once_reg    <= once_next;
         rst_reg     <= rst_next;
         rend_reg    <= rend_next;
         ff_reg      <= ff_next;
         ss_reg      <= ss_next;
         mm_reg      <= mm_next;
         hh_reg      <= hh_next;
         mon_reg     <= mon_next;
         dom_reg     <= dom_next;
         wday_reg    <= wday_next;
         leap_reg    <= leap_next;
         mode_reg    <= mode_next;
         dst_on_reg  <= dst_on_next;
         fold_reg    <= fold_next;
         locm_reg    <= locm_next;
         tff_reg     <= tff_next;
         tss_reg     <= tss_next;
         tmm_reg     <= tmm_next;
         thh_reg     <= thh_next;
      end
   end

   assign tc_ff        = tff_reg;
   assign tc_ss        = tss_reg;
   assign tc_mm        = tmm_reg;
   assign tc_hh        = thh_reg;
   assign tc_drop      = drop != 3'h0;
   assign shift_active = dst_on_reg;

   // checks
   logic wr_time, wr_ctrl;
   assign wr_time = wr_en && a_addr_reg == tcj_pkg::OFS_TIME;
   assign wr_ctrl = wr_en && a_addr_reg == tcj_pkg::OFS_CTRL;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_min_roll;
      frame_tick && 6'(ff_reg) == top && ss_reg == tcj_pkg::SEC_TOP && !wr_time;
   endsequence

   frame_wrap_a: assert property (                                      // R1
      frame_tick && rate_reg == tcj_pkg::RATE_30 && ff_reg == FRAME_W'(29)
      && ss_reg != tcj_pkg::SEC_TOP && !wr_time
      |=> ff_reg == '0 && ss_reg == $past(ss_reg) + 6'h01)
      else $error("frame field did not wrap into next second");
   int_rate_a: assert property (                                        // R2
      s_min_roll ##0 (drop == 3'h0) |=> ff_reg == '0)
      else $error("integer rate skipped frames");
   drop_skip_a: assert property (                                       // R3
      s_min_roll ##0 (rate_reg == tcj_pkg::RATE_2997
      && (next_mod % 11'h00A) != 11'h000 && !jam_hit) |=> ff_reg == FRAME_W'(2))
      else $error("drop minute did not start at frame 02");
   tenth_min_a: assert property (                                       // R4
      s_min_roll ##0 ((next_mod % 11'h00A) == 11'h000 && !jam_hit) |=> ff_reg == '0)
      else $error("tenth minute skipped frames");
   jam_extra_a: assert property (                                       // R5
      s_min_roll ##0 (jam_hit && rate_reg == tcj_pkg::RATE_2997
      && (next_mod % 11'h00A) == 11'h000) |=> ff_reg == FRAME_W'(2))
      else $error("jam sync did not skip two counts");
   jam_sixty_a: assert property (                                       // R6
      s_min_roll ##0 (jam_hit && rate_reg == tcj_pkg::RATE_5994
      && (next_mod % 11'h00A) == 11'h000) |=> ff_reg == FRAME_W'(4))
      else $error("jam sync at 59.94 wrong skip");
   jam_off_a: assert property (                                         // R7
      s_min_roll ##0 (!jam_en_reg && (next_mod % 11'h00A) == 11'h000) |=> ff_reg == '0)
      else $error("jam sync while disabled");
   local_out_a: assert property (                                       // R9
      ##1 11'(thh_reg) * tcj_pkg::MIN_PER_HR + 11'(tmm_reg) == $past(loc_mod))
      else $error("local time output mismatch");
   shift_off_a: assert property (                                       // R10
      mode_reg != tcj_pkg::MODE_RECUR |=> !dst_on_reg)
      else $error("shift active outside recurring mode");
   once_back_a: assert property (                                       // R11
      once_hit && !wr_ctrl |=> mode_reg == tcj_pkg::MODE_OFF
      && fold_reg == $past(fold_reg) + $past(ofs_min(shift_reg)))
      else $error("single shift not applied or mode kept");
   recur_on_a: assert property (                                        // R16
      ev && start_hit && mode_reg == tcj_pkg::MODE_RECUR && !wr_ctrl
      |=> dst_on_reg ##1 (dst_on_reg || $past(ev && end_hit) || $past(wr_ctrl)))
      else $error("shift not started at start event");
   recur_off_a: assert property (                                       // R16
      ev && end_hit && !start_hit |=> !dst_on_reg)
      else $error("shift not ended at end event");
endmodule : tcj_timecode
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        hclk, hresetn, hsel, hwrite, frame_tick;
   logic [31:0] haddr, hwdata, rd, sd, t0;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, tc_drop, shift_active;
   logic [31:0] hrdata, tcw;
   logic [4:0]  tc_hh;
   logic [5:0]  tc_mm, tc_ss, tc_ff;
   int          n_fail, samples_checked, n;
   assign tcw = {3'h0, tc_hh, 2'h0, tc_mm, 2'h0, tc_ss, 2'h0, tc_ff};
   tcj_timecode dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .frame_tick(frame_tick),
      .tc_hh(tc_hh), .tc_mm(tc_mm), .tc_ss(tc_ss), .tc_ff(tc_ff), .tc_drop(tc_drop),
      .shift_active(shift_active));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   function automatic logic [31:0] tw(input int h, input int m, input int s, input int f);
      return {3'h0, 5'(h), 2'h0, 6'(m), 2'h0, 6'(s), 2'h0, 6'(f)};
   endfunction : tw
   // plain 30 frame count, no skips
   function automatic logic [31:0] adv(input logic [31:0] t, input int k);
      int x;
      x = int'(t[28:24]) * 60 + int'(t[21:16]);
      x = ((x * 60 + int'(t[13:8])) * 30 + int'(t[5:0]) + k) % 2592000;
      return tw(x / 108000, x / 1800 % 60, x / 30 % 60, x % 30);
   endfunction : adv
   task automatic report_and_stop();
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
      rd = hrdata;
      if (k >= 50) begin
         n_fail++;
         report_and_stop();
      end
   endtask : bus
   task automatic tick(input int cnt);
      frame_tick <= 1'b1;
      repeat (cnt) @(posedge hclk);
      frame_tick <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask : tick
   task automatic rst();
      hresetn <= 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask : rst
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   initial begin
      repeat (100000) @(posedge hclk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      static int rt[6] = '{2, 3, 3, 6, 11, 14};
      static int mi[6] = '{7, 7, 9, 7, 9, 9};
      static int tp[6] = '{29, 29, 29, 59, 29, 59};
      static int ef[6] = '{0, 2, 0, 4, 2, 4};
      {hresetn, hsel, hwrite, frame_tick, htrans} = '0;
      {haddr, hwdata} = '0;
      hsize = 3'h2;
      n_fail = 0;
      samples_checked = 0;
      sd = 32'hE944;
      rst();
      bus(1'b0, tcj_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_0003);
      for (int r = 0; r < 7; r++) begin
         bus(1'b1, tcj_pkg::OFS_CTRL, 32'(r));
         @(posedge hclk);
         chk({31'h0, tc_drop}, 32'(r == 3 || r == 6));
      end
      bus(1'b1, tcj_pkg::OFS_CTRL, 32'h0000_0002);
      repeat (8) begin
         sd = xs(sd);
         t0 = tw(sd[7:0] % 23, sd[13:8] % 60, sd[21:16] % 60, sd[29:24] % 30);
         n = 1 + int'(sd[31:27]) * 2;
         bus(1'b1, tcj_pkg::OFS_TIME, t0);
         tick(n);
         chk(tcw, adv(t0, n));
      end
      bus(1'b1, tcj_pkg::OFS_JAM, 32'h0000_000A);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, tcj_pkg::OFS_CTRL, 32'(rt[i]));
         bus(1'b1, tcj_pkg::OFS_TIME, tw(0, mi[i], 59, tp[i]));
         tick(1);
         chk(tcw, tw(0, mi[i] + 1, 0, ef[i]));
      end
      bus(1'b1, tcj_pkg::OFS_CTRL, 32'h0000_0002);
      bus(1'b1, tcj_pkg::OFS_ZONE, 32'h0000_0200);
      bus(1'b1, tcj_pkg::OFS_TIME, tw(1, 0, 0, 0));
      tick(1);
      chk(tcw, tw(3, 0, 0, 1));
      bus(1'b1, tcj_pkg::OFS_ZONE, 32'h0000_8100);
      tick(1);
      chk(tcw, tw(0, 0, 0, 2));
      bus(1'b1, tcj_pkg::OFS_ZONE, 32'h0);
      bus(1'b1, tcj_pkg::OFS_SHIFT, 32'h0000_0100);
      bus(1'b1, tcj_pkg::OFS_ONCE, 32'h0101_0005);
      bus(1'b1, tcj_pkg::OFS_TIME, tw(0, 4, 59, 29));
      tick(1);
      chk(tcw, tw(0, 5, 0, 0));
      bus(1'b1, tcj_pkg::OFS_CTRL, 32'h0000_0012);
      bus(1'b1, tcj_pkg::OFS_TIME, tw(0, 4, 59, 29));
      tick(1);
      chk(tcw, tw(1, 5, 0, 0));
      bus(1'b0, tcj_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_0002);
      rst();
      chk(tcw, 32'h0);
      bus(1'b1, tcj_pkg::OFS_SHIFT, 32'h0000_0100);
      bus(1'b1, tcj_pkg::OFS_RSTART, 32'h0110_0006);
      bus(1'b1, tcj_pkg::OFS_REND, 32'h0110_0107);
      bus(1'b1, tcj_pkg::OFS_CTRL, 32'h0000_0032);
      bus(1'b1, tcj_pkg::OFS_TIME, tw(0, 5, 59, 29));
      tick(1);
      chk({shift_active, tcw[30:0]}, {1'b1, 31'(tw(1, 6, 0, 0))});
      bus(1'b1, tcj_pkg::OFS_TIME, tw(0, 6, 59, 29));
      tick(1);
      chk({shift_active, tcw[30:0]}, {1'b0, 31'(tw(0, 7, 0, 0))});
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
